// *** eelc_top.sv ***
`timescale 1ns/100ps
`include "eelc_defs.svh"

module eelc_top (
    // clock and reset
    input  wire logic                       CLK_I,
    input  wire logic                       NRST_I,
    // register port
    input  wire logic [`EELC_AW-1:0]        ADDR_I,
    input  wire logic [31:0]                WDATA_I,
    input  wire logic                       WR_I,
    input  wire logic                       RD_I,
    output logic      [31:0]                RDATA_O,
    // pins
    input  wire logic [`EELC_NPINS-1:0]     PIN_I,
    input  wire logic [1:0]                 INT_LINE_I,
    // requests
    output logic      [`EELC_NLINES-1:0]    IRQ_O,
    output logic      [`EELC_NLINES-1:0]    EVT_O,
    output logic                            INT_O
);
    eelc_pkg::eelc_cfg_s          cfg_r, cfg_nxt;
    logic [`EELC_NLINES-1:0]      pend_r, pend_nxt;
    logic [`EELC_NLINES-1:0]      evt_r, evt_nxt;
    logic [`EELC_NLINES-1:0]      irq_r, irq_nxt;
    logic [1:0]                   stat_r, stat_nxt;
    logic [1:0]                   ien_r, ien_nxt;
    logic                         int_r, int_nxt;
    logic [31:0]                  rdata_r, rdata_nxt;
    logic [`EELC_SELW-1:0]        sel_r [`EELC_NPINLINES];
    logic [`EELC_SELW-1:0]        sel_nxt [`EELC_NPINLINES];
    logic [`EELC_NLINES-1:0]      line_src;
    logic [`EELC_NLINES-1:0]      hit;
    logic [`EELC_NLINES-1:0]      swtrig;
    logic                         wr_sel;
    logic [3:0]                   sel_reg;

    // ============================================================
    // pin routing and capture
    genvar g;
    generate
        for (g = 0; g < `EELC_NLINES; g++) begin : g_line
            if (g < `EELC_NPINLINES) begin : g_pin
                // codes past the last pin read low instead of unknown
                assign line_src[g] = (sel_r[g] < 7'(`EELC_NPINS)) ? PIN_I[sel_r[g]] : 1'b0;
            end else begin : g_int
                assign line_src[g] = INT_LINE_I[g-`EELC_NPINLINES];
            end
            eelc_capture u_cap (
                .clk_i     (CLK_I),
                .nrst_i    (NRST_I),
                .line_i    (line_src[g]),
                .rise_en_i (cfg_r.rise[g]),
                .fall_en_i (cfg_r.fall[g]),
                .edge_o    (hit[g])
            );
        end
    endgenerate

    // ============================================================
    // registers
    // four select words only; higher offsets fall outside and are refused
    assign wr_sel  = WR_I && ADDR_I >= `EELC_OFS_SELBASE;
    assign sel_reg = 4'((ADDR_I - `EELC_OFS_SELBASE) >> 2);
    // software trigger is a one-cycle strobe, so it joins the edge hits
    assign swtrig  = (WR_I && ADDR_I == `EELC_OFS_SWTRIG) ? WDATA_I[17:0] : `EELC_RST_MASK;

    always_comb begin
        logic [`EELC_NLINES-1:0] trig;
        trig      = hit | swtrig;
        cfg_nxt   = cfg_r;
        ien_nxt   = ien_r;
        for (int i = 0; i < `EELC_NPINLINES; i++) begin
            sel_nxt[i] = sel_r[i];
        end
        if (WR_I) begin
            unique case (ADDR_I)
                `EELC_OFS_IMASK: cfg_nxt.imask = WDATA_I[17:0];
                `EELC_OFS_EMASK: cfg_nxt.emask = WDATA_I[17:0];
                `EELC_OFS_RISE:  cfg_nxt.rise  = WDATA_I[17:0];
                `EELC_OFS_FALL:  cfg_nxt.fall  = WDATA_I[17:0];
                `EELC_OFS_IEN:   ien_nxt       = WDATA_I[1:0];
                default: ;
            endcase
        end
        // one byte per line, low seven bits used
        if (wr_sel && sel_reg < 4'(`EELC_NSELREG)) begin
            for (int k = 0; k < 4; k++) begin
                sel_nxt[sel_reg*4+k] = WDATA_I[k*8 +: `EELC_SELW];
            end
        end
        // pending: write one clears, but a new edge in the same cycle wins
        pend_nxt = pend_r;
        if (WR_I && ADDR_I == `EELC_OFS_PEND) begin
            pend_nxt = pend_r & ~WDATA_I[17:0];
        end
        pend_nxt = pend_nxt | (trig & cfg_r.imask);
        // irq is the pending level itself, so it needs no clear of its own
        irq_nxt  = pend_nxt;
        evt_nxt  = trig & cfg_r.emask;
        // status: overrun = edge on an already pending line
        stat_nxt = stat_r;
        if (WR_I && ADDR_I == `EELC_OFS_CLR) begin
            stat_nxt = stat_r & ~WDATA_I[1:0];
        end
        stat_nxt[`EELC_STAT_OVR] = stat_nxt[`EELC_STAT_OVR] | (|(trig & cfg_r.imask & pend_r));
        stat_nxt[`EELC_STAT_ANY] = stat_nxt[`EELC_STAT_ANY] | (|(trig & cfg_r.imask));
        int_nxt  = |(stat_nxt & ien_nxt);
        // read data stand one cycle only, zero otherwise
        rdata_nxt = 32'h0000_0000;
        if (RD_I) begin
            unique case (ADDR_I)
                `EELC_OFS_IMASK: rdata_nxt = {14'h0000, cfg_r.imask};
                `EELC_OFS_EMASK: rdata_nxt = {14'h0000, cfg_r.emask};
                `EELC_OFS_RISE:  rdata_nxt = {14'h0000, cfg_r.rise};
                `EELC_OFS_FALL:  rdata_nxt = {14'h0000, cfg_r.fall};
                `EELC_OFS_PEND:  rdata_nxt = {14'h0000, pend_r};
                `EELC_OFS_STAT:  rdata_nxt = {30'h0000_0000, stat_r};
                `EELC_OFS_IEN:   rdata_nxt = {30'h0000_0000, ien_r};
                default: begin
                    if (ADDR_I >= `EELC_OFS_SELBASE && sel_reg < 4'(`EELC_NSELREG)) begin
                        for (int k = 0; k < 4; k++) begin
                            rdata_nxt[k*8 +: `EELC_SELW] = sel_r[sel_reg*4+k];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cfg_r   <= '0;
            pend_r  <= `EELC_RST_MASK;
            evt_r   <= `EELC_RST_MASK;
            irq_r   <= `EELC_RST_MASK;
            stat_r  <= 2'h0;
            ien_r   <= 2'h0;
            int_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
            for (int i = 0; i < `EELC_NPINLINES; i++) begin
                sel_r[i] <= 7'h00;
            end
        end else begin
            cfg_r   <= cfg_nxt;
            pend_r  <= pend_nxt;
            evt_r   <= evt_nxt;
            irq_r   <= irq_nxt;
            stat_r  <= stat_nxt;
            ien_r   <= ien_nxt;
            int_r   <= int_nxt;
            rdata_r <= rdata_nxt;
            for (int i = 0; i < `EELC_NPINLINES; i++) begin
                sel_r[i] <= sel_nxt[i];
            end
        end
    end

    assign RDATA_O = rdata_r;
    assign IRQ_O   = irq_r;
    assign EVT_O   = evt_r;
    assign INT_O   = int_r;

    // ============================================================
    // checks
    sequence s_sw_trig0;
        WR_I && ADDR_I == `EELC_OFS_SWTRIG && WDATA_I[0];
    endsequence

    sequence s_pend_clr0;
        WR_I && ADDR_I == `EELC_OFS_PEND && WDATA_I[0];
    endsequence

    sequence s_stat_clr;
        WR_I && ADDR_I == `EELC_OFS_CLR && WDATA_I[`EELC_STAT_ANY];
    endsequence

    sequence s_sel_wr0;
        WR_I && ADDR_I == `EELC_OFS_SELBASE;
    endsequence

    a_pend_sets: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (s_sw_trig0 and cfg_r.imask[0]) |=> pend_r[0]) else $error("pending not set");
    a_mask_blocks: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (pend_r & ~$past(cfg_r.imask) & ~$past(pend_r)) == 18'h00000) else $error("masked line pended");
    a_pend_holds: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        pend_r[0] && !(WR_I && ADDR_I == `EELC_OFS_PEND) |=> pend_r[0]) else $error("pending lost");
    a_clear_works: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        WR_I && ADDR_I == `EELC_OFS_PEND && WDATA_I[0] && !hit[0] |=> !pend_r[0]) else $error("no clear");
    a_irq_follows: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (s_sw_trig0 and cfg_r.imask[0]) |=> IRQ_O[0]) else $error("irq not raised");
    a_evt_masked: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (EVT_O & ~$past(cfg_r.emask)) == 18'h00000) else $error("masked event");
    a_hit_pulse: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        hit[0] |=> !hit[0]) else $error("edge not one pulse");
    a_int_level: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        INT_O == |(stat_r & ien_r)) else $error("int wrong");

    // ============================================================
    // register side checks
    a_evt_forward: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (s_sw_trig0 and cfg_r.emask[0]) |=> EVT_O[0]) else $error("event not forwarded");
    a_irq_drops: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (s_pend_clr0 and !hit[0]) |=> !IRQ_O[0]) else $error("irq not dropped");
    a_ovr_sets: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (s_sw_trig0 and (cfg_r.imask[0] && pend_r[0])) |=> stat_r[`EELC_STAT_OVR]) else $error("no overrun");
    a_any_sets: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (s_sw_trig0 and cfg_r.imask[0]) |=> stat_r[`EELC_STAT_ANY]) else $error("status not set");
    a_stat_clears: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (s_stat_clr and !(|(hit & cfg_r.imask))) |=> !stat_r[`EELC_STAT_ANY]) else $error("status kept");
    a_sel_route: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        s_sel_wr0 |=> sel_r[0] == $past(WDATA_I[`EELC_SELW-1:0])) else $error("select not stored");
    a_rd_idle: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        !RD_I |=> RDATA_O == 32'h0000_0000) else $error("read data without read");

    // per line: one pulse per captured edge, and it pends when unmasked
    for (genvar c = 0; c < `EELC_NLINES; c++) begin : g_chk
        a_line_pulse: assert property (@(posedge CLK_I) disable iff (!NRST_I)
            hit[c] |=> !hit[c]) else $error("line edge not one pulse");
        a_line_pends: assert property (@(posedge CLK_I) disable iff (!NRST_I)
            hit[c] && cfg_r.imask[c] |=> IRQ_O[c]) else $error("line edge not pended");
    end
endmodule : eelc_top

// *** eelc_defs.svh ***
// Contract
// - eighteen independent edge lines, each raising interrupt or event request
// - per line trigger choice: rising only, falling only, or both edges
// - per line mask; masked line forwards nothing, others unaffected
// - readable pending flag per line records a triggered request
// - pulses shorter than one bus clock period are still caught
// - selector routes one of 112 pins onto each of 16 pin lines
`ifndef EELC_DEFS_SVH
`define EELC_DEFS_SVH

// ============================================================
// sizes
`define EELC_NLINES      18
`define EELC_NPINLINES   16
`define EELC_NPINS       112
`define EELC_SELW        7
`define EELC_AW          6

// ============================================================
// register offsets
`define EELC_OFS_IMASK   6'h00
`define EELC_OFS_EMASK   6'h04
`define EELC_OFS_RISE    6'h08
`define EELC_OFS_FALL    6'h0C
`define EELC_OFS_SWTRIG  6'h10
`define EELC_OFS_PEND    6'h14
`define EELC_OFS_STAT    6'h18
`define EELC_OFS_CLR     6'h1C
`define EELC_OFS_IEN     6'h20
`define EELC_OFS_SELBASE 6'h24
`define EELC_NSELREG     4

// ============================================================
// reset values and status bits
`define EELC_RST_MASK    18'h00000
`define EELC_STAT_OVR    0
`define EELC_STAT_ANY    1

`endif

// *** eelc_pkg.sv ***
package eelc_pkg;
    typedef struct packed {
        logic [17:0] imask;
        logic [17:0] emask;
        logic [17:0] rise;
        logic [17:0] fall;
    } eelc_cfg_s;
endpackage : eelc_pkg

// *** eelc_capture.sv ***
`timescale 1ns/100ps
`include "eelc_defs.svh"

// ============================================================
// asynchronous edge latch for one line: a pulse shorter than a clock
// period sets the latch directly; the clock domain acks it back
module eelc_capture (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // line
    input  wire logic line_i,
    input  wire logic rise_en_i,
    input  wire logic fall_en_i,
    // output
    output logic      edge_o
);
    logic rise_hit;
    logic fall_hit;
    logic ack_r;
    logic clr;
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // reset clears the latches too, so no unknown leaks out after power-up
    assign clr = ack_r | ~nrst_i;

    // the line itself is the clock of the latch, so no clock width is needed
    always_ff @(posedge line_i or posedge clr) begin
        if (clr) begin
            rise_hit <= 1'b0;
        end else begin
            rise_hit <= rise_en_i;
        end
    end

    always_ff @(negedge line_i or posedge clr) begin
        if (clr) begin
            fall_hit <= 1'b0;
        end else begin
            fall_hit <= fall_en_i;
        end
    end

    // two-stage sync; s1 read only by s2
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            s1_r  <= rise_hit | fall_hit;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            ack_r <= s2_r;
        end
    end

    assign edge_o = s2_r & ~s3_r;
endmodule : eelc_capture

// *** eelc_pin_model.sv ***
`timescale 1ns/100ps
`include "eelc_defs.svh"

// ============================================================
// pin side of the block: levels hold between calls, idle low
module eelc_pin_model (
    // pins and extra lines
    output logic [`EELC_NPINS-1:0] pin_o,
    output logic [1:0]             line_o
);
    initial begin
        pin_o  = '0;
        line_o = '0;
    end

    // glitch far shorter than a clock, only an async latch sees it
    task automatic glitch(input int idx, input realtime w);
        pin_o[idx] = ~pin_o[idx];
        #(w);
        pin_o[idx] = ~pin_o[idx];
    endtask : glitch

    task automatic set_line(input int k, input logic v);
        line_o[k] = v;
    endtask : set_line
endmodule : eelc_pin_model

// *** testbench.sv ***
`timescale 1ns/100ps
`include "eelc_defs.svh"

module testbench;
    logic                    CLK_I;
    logic                    NRST_I;
    logic [`EELC_AW-1:0]     ADDR_I;
    logic [31:0]             WDATA_I;
    logic                    WR_I;
    logic                    RD_I;
    logic [31:0]             RDATA_O;
    logic [`EELC_NPINS-1:0]  PIN_I;
    logic [1:0]              INT_LINE_I;
    logic [`EELC_NLINES-1:0] IRQ_O;
    logic [`EELC_NLINES-1:0] EVT_O;
    logic                    INT_O;
    int                      n_errors = 0;
    int                      n_checks = 0;
    int                      evt_cnt  = 0;

    eelc_pin_model pins (.pin_o(PIN_I), .line_o(INT_LINE_I));
    eelc_top uut (.CLK_I(CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
                  .RD_I(RD_I), .RDATA_O(RDATA_O), .PIN_I(PIN_I), .INT_LINE_I(INT_LINE_I),
                  .IRQ_O(IRQ_O), .EVT_O(EVT_O), .INT_O(INT_O));

    // ============================================================
    // helpers
    task automatic summarize();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge CLK_I);
    endtask : idle

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        ADDR_I  <= a;
        WDATA_I <= d;
        WR_I    <= 1'b1;
        @(posedge CLK_I);
        WR_I    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        @(posedge CLK_I);
        ADDR_I <= a;
        RD_I   <= 1'b1;
        @(posedge CLK_I);
        RD_I   <= 1'b0;
        #1;
        chk(RDATA_O, e);
    endtask : rd

    task automatic wait_irq(input int b);
        for (int i = 0; i < 20 && IRQ_O[b] !== 1'b1; i++) @(posedge CLK_I);
        if (IRQ_O[b] !== 1'b1) begin
            $display("unexpected t=%0t got %h exp %h", $time, IRQ_O[b], 1'b1);
            n_errors++;
            summarize();
        end
    endtask : wait_irq

    always @(posedge CLK_I) if (EVT_O[0] === 1'b1) evt_cnt <= evt_cnt + 1;

    // ============================================================
    // clock and watchdog
    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end

    initial begin
        #200us;
        n_errors++;
        summarize();
    end

    // ============================================================
    // main sequence
    initial begin
        NRST_I  = 1'b0;
        ADDR_I  = '0;
        WDATA_I = '0;
        WR_I    = 1'b0;
        RD_I    = 1'b0;
        idle(6);
        NRST_I <= 1'b1;
        chk({13'h0, INT_O, IRQ_O}, 32'h0);
        rd(`EELC_OFS_IMASK, 32'h0);
        rd(`EELC_OFS_PEND, 32'h0);
        rd(6'h3C, 32'h0);
        // line 0 from pin 5, line 1 from the top pin
        wr(`EELC_OFS_SELBASE, 32'h00006F05);
        wr(`EELC_OFS_RISE, 32'h00020003);
        wr(`EELC_OFS_FALL, 32'h00030000);
        wr(`EELC_OFS_IMASK, 32'h00030001);
        wr(`EELC_OFS_EMASK, 32'h00000001);
        wr(`EELC_OFS_IEN, 32'h00000002);
        rd(`EELC_OFS_RISE, 32'h00020003);
        rd(`EELC_OFS_FALL, 32'h00030000);
        // offset past the four select words must leave them alone
        wr(6'h34, 32'h7F7F7F7F);
        rd(`EELC_OFS_SELBASE, 32'h00006F05);
        pins.glitch(5, 3.0);
        wait_irq(0);
        idle(3);
        rd(`EELC_OFS_PEND, 32'h1);
        chk(evt_cnt, 32'h1);
        chk(INT_O, 32'h1);
        // masked line 1 must stay quiet beside line 0
        pins.glitch(111, 3.0);
        idle(10);
        rd(`EELC_OFS_PEND, 32'h1);
        chk(IRQ_O, 32'h1);
        wr(`EELC_OFS_PEND, 32'h1);
        rd(`EELC_OFS_PEND, 32'h0);
        pins.glitch(4, 3.0);
        idle(10);
        rd(`EELC_OFS_PEND, 32'h0);
        // line 16 falling only, line 17 both edges
        pins.set_line(0, 1'b1);
        idle(10);
        rd(`EELC_OFS_PEND, 32'h0);
        pins.set_line(0, 1'b0);
        wait_irq(16);
        rd(`EELC_OFS_PEND, 32'h10000);
        pins.set_line(1, 1'b1);
        wait_irq(17);
        rd(`EELC_OFS_PEND, 32'h30000);
        wr(`EELC_OFS_PEND, 32'h20000);
        rd(`EELC_OFS_PEND, 32'h10000);
        pins.set_line(1, 1'b0);
        wait_irq(17);
        rd(`EELC_OFS_PEND, 32'h30000);
        // software trigger on line 0 twice: the second one overruns
        wr(`EELC_OFS_SWTRIG, 32'h00000001);
        wr(`EELC_OFS_SWTRIG, 32'h00000001);
        rd(`EELC_OFS_PEND, 32'h30001);
        rd(`EELC_OFS_STAT, 32'h3);
        chk(evt_cnt, 32'h3);
        // interrupt output: enable gates it, clears drop it
        wr(`EELC_OFS_IEN, 32'h0);
        idle(2);
        chk(INT_O, 32'h0);
        wr(`EELC_OFS_PEND, 32'h30001);
        wr(`EELC_OFS_CLR, 32'h3);
        wr(`EELC_OFS_IEN, 32'h2);
        idle(2);
        chk(INT_O, 32'h0);
        rd(`EELC_OFS_STAT, 32'h0);
        summarize();
    end
endmodule : testbench
